// ==== dv/test_touch_switch_and_numeral_notifier.sv ====
`timescale 1ns/10ps
module test_touch_switch_and_numeral_notifier import tsn_pkg::*; ;
  logic i_clk_sys, i_nrst, legacy, word_link, scr, wr_ready, num_done, sent, slow, strobe, ce;
  tsn_cfg_type [3:0] cfg;
  logic [3:0] pressed, lamp, attr, notify, lit, flash;
  logic [3:0][15:0] snap, mem;
  logic [9:0] idx;
  logic [11:0] uidx, idx_seen;
  tsn_wr_type wr;
  int n_errors, tests_run;
  tsn_notifier u_tsn_notifier (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(ce),
    .i_legacy_link(legacy), .i_word_link(word_link), .i_sw_cfg(cfg), .i_sw_pressed(pressed),
    .i_screen_change(scr), .i_snap_word(snap), .i_lamp_bits(lamp), .i_lamp_flash_attr(attr),
    .i_wr_ready(wr_ready), .i_num_done(num_done), .i_num_index(idx), .i_strobe_sent(sent),
    .o_wr(wr), .o_notify_bits(notify), .o_lamp_lit(lit), .o_lamp_flash(flash),
    .o_strobe(strobe), .o_update_index(uidx));
  tsn_host_model u_tsn_host_model (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_slow(slow),
    .i_wr(wr), .i_strobe(strobe), .i_update_index(uidx), .o_wr_ready(wr_ready),
    .o_strobe_sent(sent), .o_idx_seen(idx_seen), .o_mem(mem));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // waits until the write port has gone quiet, bounded
  task automatic wait_idle;
    int k;
    repeat (3) @(posedge i_clk_sys);
    #1;
    for (k = 0; k < 20 && wr.valid !== 1'b0; k++) begin
      @(posedge i_clk_sys);
      #1;
    end
    check(16'(wr.valid), 16'h0);
  endtask
  task automatic press(input int s, input logic v);
    @(posedge i_clk_sys);
    pressed[s] <= v;
    wait_idle;
  endtask
  task automatic t_momentary;
    @(posedge i_clk_sys);
    word_link <= 1'b1;
    press(0, 1'b1);
    check(16'(notify[0]), 16'h1);
    check(mem[0], 16'h0008);
    press(0, 1'b0);
    check(16'(notify[0]), 16'h0);
    check(mem[0], 16'h0000);
  endtask
  task automatic t_screen;
    press(0, 1'b1);
    @(posedge i_clk_sys);
    scr <= 1'b1;
    @(posedge i_clk_sys);
    scr <= 1'b0;
    wait_idle;
    check(16'(notify[0]), 16'h0);
    check(mem[0], 16'h0000);
    press(0, 1'b0);
  endtask
  task automatic t_alternate;
    slow <= 1'b1;
    press(1, 1'b1);
    check(mem[1], 16'h9234);
    press(1, 1'b0);
    press(1, 1'b1);
    check(mem[1], 16'h1234);
    check(16'(notify[1]), 16'h0);
    press(1, 1'b0);
    slow <= 1'b0;
  endtask
  task automatic t_bitmode;
    word_link <= 1'b0;
    for (int s = 2; s < 4; s++) begin
      repeat (2) begin
        press(s, 1'b1);
        press(s, 1'b0);
      end
    end
    check(mem[2], 16'h5A5B);
    check(16'(notify[2]), 16'h1);
    check(mem[3], 16'h5A1A);
    check(16'(notify[3]), 16'h0);
  endtask
  task automatic t_legacy;
    legacy <= 1'b1;
    press(1, 1'b1);
    check(16'(notify[1]), 16'h1);
    press(1, 1'b0);
    check(16'(notify[1]), 16'h0);
    legacy <= 1'b0;
  endtask
  task automatic t_lamps;
    @(posedge i_clk_sys);
    lamp <= 4'h6;
    attr <= 4'h4;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check(16'({lit, flash}), 16'h0024);
    lamp <= 4'h0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check(16'({lit, flash}), 16'h0000);
    // with the enable low the lamp change must not be taken
    @(posedge i_clk_sys);
    ce <= 1'b0;
    lamp <= 4'h1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check(16'({lit, flash}), 16'h0000);
    @(posedge i_clk_sys);
    ce <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check(16'({lit, flash}), 16'h0010);
    @(posedge i_clk_sys);
    lamp <= 4'h0;
  endtask
  task automatic t_numeral(input logic [9:0] v, input logic [11:0] exp);
    int k;
    @(posedge i_clk_sys);
    num_done <= 1'b1;
    idx <= v;
    @(posedge i_clk_sys);
    num_done <= 1'b0;
    #1;
    for (k = 0; k < 10 && strobe !== 1'b1; k++) @(posedge i_clk_sys) #1;
    check(16'(strobe), 16'h1);
    // the host captures the index on the same edge at which it sees the strobe rise
    @(posedge i_clk_sys);
    #1;
    check(16'(idx_seen), 16'(exp));
    for (k = 0; k < 10 && strobe !== 1'b0; k++) @(posedge i_clk_sys) #1;
    check(16'(strobe), 16'h0);
  endtask
  initial begin
    {i_nrst, legacy, word_link, scr, num_done, slow, pressed, lamp, attr, idx} = '0;
    ce = 1'b1;
    snap = {16'h0040, 16'h0000, 16'h1234, 16'h0000};
    cfg[0] = '{word: 16'h0000, bitpos: 4'h3, op: TSN_MOMENTARY, data_memory_area: 1'b1};
    cfg[1] = '{word: 16'h0001, bitpos: 4'hF, op: TSN_ALTERNATE, data_memory_area: 1'b1};
    cfg[2] = '{word: 16'h0002, bitpos: 4'h0, op: TSN_SET, data_memory_area: 1'b0};
    cfg[3] = '{word: 16'h0003, bitpos: 4'h6, op: TSN_RESET, data_memory_area: 1'b0};
    repeat (3) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t_momentary;
    t_screen;
    t_alternate;
    t_bitmode;
    t_legacy;
    t_lamps;
    t_numeral(10'd3, 12'h003);
    t_numeral(10'd421, 12'h421);
    t_numeral(10'd1000, 12'h999);
    wrap_up;
  end
  // the full sequence needs well under 1000 cycles
  initial begin
    #20000;
    n_errors++;
    wrap_up;
  end
endmodule // test_touch_switch_and_numeral_notifier

// ==== dv/tsn_host_model.sv ====
`timescale 1ns/10ps
module tsn_host_model import tsn_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_slow,
  input tsn_wr_type i_wr,
  input wire logic i_strobe,
  input wire logic [TSN_BCD_W-1:0] i_update_index,
  output logic o_wr_ready,
  output logic o_strobe_sent,
  output logic [TSN_BCD_W-1:0] o_idx_seen,
  output logic [3:0][TSN_WORD_W-1:0] o_mem
);
  logic strobe_r;
  logic [1:0] cnt_r;
  // host words start non-zero so that untouched bits stay visible
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_mem <= {4{16'h5A5A}};
      o_wr_ready <= 1'b0;
      o_strobe_sent <= 1'b0;
      o_idx_seen <= 12'h000;
      strobe_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      o_wr_ready <= i_slow ? !o_wr_ready : 1'b1;
      if (i_wr.valid && o_wr_ready) begin
        o_mem[i_wr.word[1:0]] <= (o_mem[i_wr.word[1:0]] & ~i_wr.mask) | (i_wr.data & i_wr.mask);
      end
      strobe_r <= i_strobe;
      if (i_strobe && !strobe_r) begin
        o_idx_seen <= i_update_index;
      end
      // delivery takes a few cycles, as a scanning host would
      cnt_r <= i_strobe ? cnt_r + 2'h1 : 2'h0;
      o_strobe_sent <= i_strobe && (cnt_r == 2'h2);
    end
  end
endmodule // tsn_host_model

// ==== rtl/tsn_notifier.sv ====
`timescale 1ns/10ps
// Overview of operation
// - lamp output unlit while host lamp bit is 0, lit or flashing while 1.
// - momentary notify bit is 1 while pressed and 0 while released.
// - alternate operation inverts the notify bit on every press.
// - set operation forces the notify bit to 1 on every press.
// - reset operation forces the notify bit to 0 on every press.
// - the legacy direct link treats every switch as momentary.
// - momentary writes on word links in data memory clear the rest of the word.
// - other types on word links write over the word captured at display.
// - a screen change while a momentary key is held reports it released.
// - bit links or other areas replace only the one notify bit.
// - each bit is a word number plus a position 0 to 15.
// - a finished numeric entry raises the entry strobe flag.
// - the changed table number goes to the index word as three BCD digits.
// - the strobe drops back to 0 once delivered to the host.
module tsn_notifier import tsn_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_legacy_link,
  input wire logic i_word_link,
  input tsn_cfg_type [TSN_SLOTS-1:0] i_sw_cfg,
  input wire logic [TSN_SLOTS-1:0] i_sw_pressed,
  input wire logic i_screen_change,
  input wire logic [TSN_SLOTS-1:0][TSN_WORD_W-1:0] i_snap_word,
  input wire logic [TSN_SLOTS-1:0] i_lamp_bits,
  input wire logic [TSN_SLOTS-1:0] i_lamp_flash_attr,
  input wire logic i_wr_ready,
  input wire logic i_num_done,
  input wire logic [TSN_IDX_W-1:0] i_num_index,
  input wire logic i_strobe_sent,
  output tsn_wr_type o_wr,
  output logic [TSN_SLOTS-1:0] o_notify_bits,
  output logic [TSN_SLOTS-1:0] o_lamp_lit,
  output logic [TSN_SLOTS-1:0] o_lamp_flash,
  output logic o_strobe,
  output logic [TSN_BCD_W-1:0] o_update_index
);

  tsn_top_type s_r;
  tsn_top_type s_nxt;
  tsn_wr_type [TSN_SLOTS-1:0] req;
  logic [TSN_SLOTS-1:0] grant;
  logic load;
  logic found;

  genvar g;
  generate
    for (g = 0; g < TSN_SLOTS; g++) begin : gen_slot
      tsn_notify_slot u_slot (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_cfg(i_sw_cfg[g]),
        .i_legacy_link(i_legacy_link),
        .i_word_link(i_word_link),
        .i_pressed(i_sw_pressed[g]),
        .i_screen_change(i_screen_change),
        .i_snap_word(i_snap_word[g]),
        .i_grant(grant[g]),
        .o_req(req[g]),
        .o_bit(o_notify_bits[g])
      );
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    grant = '0;
    found = 1'b0;
    // the write port holds until taken; a slot is released only on its grant
    load = ~s_r.wr.valid | i_wr_ready;
    if (i_wr_ready) begin
      s_nxt.wr.valid = 1'b0;
    end
    if (load && i_ce) begin
      // fixed priority, lowest switch first; fine for a handful of keys
      for (int k = 0; k < TSN_SLOTS; k++) begin
        if (req[k].valid && !found) begin
          found = 1'b1;
          grant[k] = 1'b1;
          s_nxt.wr = req[k];
        end
      end
    end
    s_nxt.lamp_lit = i_lamp_bits & ~i_lamp_flash_attr;
    s_nxt.lamp_flash = i_lamp_bits & i_lamp_flash_attr;
    if (i_strobe_sent) begin
      s_nxt.strobe = 1'b0;
    end
    // index lands one cycle ahead of the strobe so an edge sampler sees it
    s_nxt.idx_wait = 1'b0;
    if (s_r.idx_wait) begin
      s_nxt.strobe = 1'b1;
    end
    if (i_num_done) begin
      s_nxt.bcd = tsn_to_bcd(i_num_index);
      s_nxt.idx_wait = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_r <= TSN_TOP_RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_wr = s_r.wr;
    o_lamp_lit = s_r.lamp_lit;
    o_lamp_flash = s_r.lamp_flash;
    o_strobe = s_r.strobe;
    o_update_index = s_r.bcd;
  end

  sequence seq_entry;
    i_ce && i_num_done;
  endsequence

  sequence seq_strobe_up;
    i_ce ##1 o_strobe;
  endsequence

  chk_lamp_follow: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce |=> (o_lamp_lit | o_lamp_flash) == $past(i_lamp_bits)
    && (o_lamp_flash & ~$past(i_lamp_flash_attr)) == '0) else $error("lamp mismatch");
  chk_index_bcd: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    seq_entry |=> o_update_index == tsn_to_bcd($past(i_num_index)))
    else $error("index word not BCD of entry");
  chk_strobe_rises: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    seq_entry |=> seq_strobe_up) else $error("strobe not raised after entry");
  chk_index_first: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(o_strobe) |-> $stable(o_update_index) && !$past(s_r.idx_wait, 2))
    else $error("strobe rose before index settled");
  chk_strobe_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && i_strobe_sent && !s_r.idx_wait |=> !o_strobe) else $error("strobe not cleared");
  chk_wr_holds: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_wr.valid && !i_wr_ready |=> o_wr.valid && $stable(o_wr.data) && $stable(o_wr.mask))
    else $error("write dropped before acceptance");

  // a low enable must hold every registered output, including a pending write
  chk_ce_freeze: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !i_ce |=> $stable(o_wr) && $stable(o_strobe) && $stable(o_update_index)
    && $stable(o_lamp_lit) && $stable(o_lamp_flash)) else $error("state moved while disabled");

  chk_lamp_exclusive: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (o_lamp_lit & o_lamp_flash) == '0) else $error("lamp both lit and flashing");

  chk_grant_onehot: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $onehot0(grant)) else $error("more than one slot granted");

  chk_wr_taken: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && found |=> o_wr.valid) else $error("granted slot not put on write port");

  chk_wr_clears: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && i_wr_ready && !found |=> !o_wr.valid) else $error("accepted write repeated");

  chk_wr_mask_set: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_wr.valid |-> o_wr.mask != '0) else $error("write replaces no bit");

  chk_strobe_cause: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(o_strobe) |-> $past(s_r.idx_wait)) else $error("strobe rose without entry");

  chk_strobe_holds: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_strobe && !i_strobe_sent |=> o_strobe) else $error("strobe dropped before delivery");

  chk_index_holds: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !(i_ce && i_num_done) |=> $stable(o_update_index)) else $error("index word moved alone");

  chk_bcd_digits: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_update_index[3:0] <= 4'h9 && o_update_index[7:4] <= 4'h9
    && o_update_index[11:8] <= 4'h9) else $error("index word digit not decimal");

endmodule // tsn_notifier

// ==== rtl/tsn_notify_slot.sv ====
`timescale 1ns/10ps
module tsn_notify_slot import tsn_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input tsn_cfg_type i_cfg,
  input wire logic i_legacy_link,
  input wire logic i_word_link,
  input wire logic i_pressed,
  input wire logic i_screen_change,
  input wire logic [TSN_WORD_W-1:0] i_snap_word,
  input wire logic i_grant,
  output tsn_wr_type o_req,
  output logic o_bit
);

  tsn_slot_type s_r;
  tsn_slot_type s_nxt;
  tsn_op_type eff_op;
  logic word_mode;
  logic change;
  logic mom_bit;
  logic [TSN_WORD_W-1:0] pos_bit;
  logic [TSN_WORD_W-1:0] base;

  always_comb begin
    s_nxt = s_r;
    change = 1'b0;
    eff_op = i_legacy_link ? TSN_MOMENTARY : i_cfg.op;
    word_mode = i_word_link & i_cfg.data_memory_area;
    mom_bit = i_pressed & ~s_r.gone;
    s_nxt.prev = i_pressed;
    if (i_screen_change) begin
      s_nxt.snap = i_snap_word;
      if (eff_op == TSN_MOMENTARY) begin
        // the key vanishes with the screen: report released until let go
        s_nxt.bit_val = 1'b0;
        s_nxt.gone = i_pressed;
        change = s_r.bit_val;
      end else begin
        s_nxt.bit_val = i_snap_word[i_cfg.bitpos];
      end
    end else if (eff_op == TSN_MOMENTARY) begin
      s_nxt.bit_val = mom_bit;
      s_nxt.gone = s_r.gone & i_pressed;
      change = mom_bit ^ s_r.bit_val;
    end else if (i_pressed & ~s_r.prev) begin
      change = 1'b1;
      case (eff_op)
        TSN_ALTERNATE: s_nxt.bit_val = ~s_r.bit_val;
        TSN_SET: s_nxt.bit_val = 1'b1;
        TSN_RESET: s_nxt.bit_val = 1'b0;
        default: s_nxt.bit_val = s_r.bit_val;
      endcase
    end
    // a fresh change beats the grant so no update is lost
    s_nxt.pending = change | (s_r.pending & ~i_grant);
  end

  always_comb begin
    pos_bit = TSN_ONE_BIT << i_cfg.bitpos;
    base = (word_mode && eff_op != TSN_MOMENTARY) ? s_r.snap : TSN_WORD_RST;
    o_req.valid = s_r.pending;
    o_req.word = i_cfg.word;
    o_req.data = s_r.bit_val ? (base | pos_bit) : (base & ~pos_bit);
    o_req.mask = word_mode ? TSN_FULL_MASK : pos_bit;
    o_bit = s_r.bit_val;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_r <= TSN_SLOT_RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  chk_momentary_level: assert property (
    i_ce && eff_op == TSN_MOMENTARY && !i_screen_change && !s_r.gone
    |=> o_bit == $past(i_pressed)) else $error("momentary bit does not follow press");
  chk_legacy_forced: assert property (
    i_ce && i_legacy_link && i_cfg.op != TSN_MOMENTARY && !i_screen_change && !s_r.gone
    |=> o_bit == $past(i_pressed)) else $error("legacy link did not force momentary");
  chk_alternate_flip: assert property (
    i_ce && eff_op == TSN_ALTERNATE && i_pressed && !s_r.prev && !i_screen_change
    |=> o_bit != $past(o_bit)) else $error("alternate press did not invert bit");
  chk_set_sticks: assert property (
    i_ce && eff_op == TSN_SET && i_pressed && !s_r.prev && !i_screen_change
    |=> o_bit && o_req.valid) else $error("set press did not give one");
  chk_reset_sticks: assert property (
    i_ce && eff_op == TSN_RESET && i_pressed && !s_r.prev && !i_screen_change
    |=> !o_bit && o_req.valid) else $error("reset press did not give zero");
  chk_screen_release: assert property (
    i_ce && i_screen_change && eff_op == TSN_MOMENTARY ##1 i_ce && i_pressed
    |-> !o_bit) else $error("held key reported pressed after screen change");
  chk_bit_scope: assert property (
    !word_mode |-> (o_req.mask == pos_bit) && ((o_req.data & ~pos_bit) == TSN_WORD_RST))
    else $error("bit mode write touches other bits");
  chk_word_scope: assert property (
    word_mode && eff_op == TSN_MOMENTARY |-> o_req.mask == TSN_FULL_MASK
    && (o_req.data & ~pos_bit) == TSN_WORD_RST) else $error("momentary word not cleared");

endmodule // tsn_notify_slot

// ==== rtl/tsn_pkg.sv ====
package tsn_pkg;

  localparam int TSN_SLOTS = 4;
  localparam int TSN_WORD_W = 16;
  localparam int TSN_POS_W = 4;
  localparam int TSN_IDX_W = 10;
  localparam int TSN_BCD_W = 12;

  localparam logic [TSN_WORD_W-1:0] TSN_WORD_RST = 16'h0000;
  localparam logic [TSN_WORD_W-1:0] TSN_FULL_MASK = 16'hFFFF;
  localparam logic [TSN_WORD_W-1:0] TSN_ONE_BIT = 16'h0001;
  localparam logic [TSN_BCD_W-1:0] TSN_BCD_RST = 12'h000;
  localparam logic [TSN_IDX_W-1:0] TSN_IDX_MAX = 10'h3E7;

  typedef enum logic [1:0] {
    TSN_MOMENTARY = 2'b00,
    TSN_ALTERNATE = 2'b01,
    TSN_SET = 2'b10,
    TSN_RESET = 2'b11
  } tsn_op_type;

  // one touch switch: host word number, bit position 0..15, operation, area
  typedef struct packed {
    logic [TSN_WORD_W-1:0] word;
    logic [TSN_POS_W-1:0] bitpos;
    tsn_op_type op;
    logic data_memory_area;
  } tsn_cfg_type;

  // write towards host memory; mask marks the bits that are replaced
  typedef struct packed {
    logic valid;
    logic [TSN_WORD_W-1:0] word;
    logic [TSN_WORD_W-1:0] data;
    logic [TSN_WORD_W-1:0] mask;
  } tsn_wr_type;

  localparam tsn_wr_type TSN_WR_RST = '0;

  typedef struct packed {
    logic bit_val;
    logic prev;
    logic gone;
    logic pending;
    logic [TSN_WORD_W-1:0] snap;
  } tsn_slot_type;

  localparam tsn_slot_type TSN_SLOT_RST = '0;

  typedef struct packed {
    tsn_wr_type wr;
    logic strobe;
    logic idx_wait;
    logic [TSN_BCD_W-1:0] bcd;
    logic [TSN_SLOTS-1:0] lamp_lit;
    logic [TSN_SLOTS-1:0] lamp_flash;
  } tsn_top_type;

  localparam tsn_top_type TSN_TOP_RST = '0;

  // entries above 999 saturate; three digits is all the index word holds
  function automatic logic [TSN_BCD_W-1:0] tsn_to_bcd(input logic [TSN_IDX_W-1:0] v);
    logic [TSN_IDX_W-1:0] c;
    c = (v > TSN_IDX_MAX) ? TSN_IDX_MAX : v;
    return {4'(c / 10'd100), 4'((c % 10'd100) / 10'd10), 4'(c % 10'd10)};
  endfunction

endpackage
